/* rod_defs.vh */
// Purpose: Constants for the rule output dispatch block
// Assumes: One clock, synchronous active-high reset
// Notes: Action codes are 4-bit, destination 0 means local
//
// Summary of operation
// RULE_01 - Each rule result fans out to three independent output slots.
// RULE_02 - Each slot selects local module or one remote IP from a table.
// RULE_03 - Action type resets to none; a none slot does nothing for either result.
// RULE_04 - Action type is one of nine encoded choices.
// RULE_05 - Analog action: true drives scaled value, false leaves channel unchanged.
// RULE_06 - Digital action: true drives configured level, false drives its complement.
// RULE_07 - Counter action: true selects start, stop or reset; false derived.
// RULE_08 - Counter false action: start gives stop, stop gives start, reset gives nothing.
// RULE_09 - Local destination applies to own channels without model selection.
// RULE_10 - Remote actions go out as network commands; local ones appear one cycle after the result. Remotes of a result arriving while busy are dropped.
`ifndef ROD_DEFS_VH
`define ROD_DEFS_VH

`define ROD_NUM_SLOTS 3
`define ROD_ACT_W 4
`define ROD_ACT_NONE 4'h0
`define ROD_ACT_ANALOG 4'h1
`define ROD_ACT_DIGITAL 4'h2
`define ROD_ACT_COUNTER 4'h3
`define ROD_ACT_PULSE 4'h4
`define ROD_ACT_TIMER 4'h5
`define ROD_ACT_FLAG 4'h6
`define ROD_ACT_MESSAGE 4'h7
`define ROD_ACT_ICOUNT 4'h8
`define ROD_CNT_W 2
`define ROD_CNT_NOP 2'h0
`define ROD_CNT_START 2'h1
`define ROD_CNT_STOP 2'h2
`define ROD_CNT_RESET 2'h3
`define ROD_RANGE_W 2
`define ROD_RANGE_0_10V 2'h0
`define ROD_RANGE_0_5V 2'h1
`define ROD_RANGE_4_20MA 2'h2
`define ROD_RANGE_0_20MA 2'h3
`define ROD_DEST_LOCAL 3'h0

`endif

/* rod_slot.v */
// Purpose: One output slot: turns a rule result into a configured action
// Assumes: Configuration is static while the engine runs
// Notes: Purely combinational decode; the top registers the results
`timescale 1ns/10ps
`default_nettype none
`include "rod_defs.vh"
module rod_slot #(
    parameter VAL_W = 12
)
(
    // Result and configuration
    input wire result_in,
    input wire [3:0] act_type_in,
    input wire [1:0] range_in,
    input wire [VAL_W-1:0] value_in,
    input wire dig_level_in,
    input wire [1:0] cnt_true_in,
    // Decoded action
    output reg ao_wr_out,
    output reg [VAL_W-1:0] ao_val_out,
    output reg do_wr_out,
    output reg do_lvl_out,
    output reg [1:0] cnt_cmd_out
);

    // Full-scale code shifts down for half-span ranges
    function [VAL_W-1:0] scale;
        input [VAL_W-1:0] v;
        input [1:0] r;
        begin
            if (r == `ROD_RANGE_0_5V)
                scale = v >> 1;
            else if (r == `ROD_RANGE_4_20MA)
                scale = v - (v >> 2) + ({VAL_W{1'b1}} >> 2);
            else
                scale = v;
        end
    endfunction

    always @*
    begin
        ao_wr_out = 1'b0;
        ao_val_out = {VAL_W{1'b0}};
        do_wr_out = 1'b0;
        do_lvl_out = 1'b0;
        cnt_cmd_out = `ROD_CNT_NOP;
        case (act_type_in)
            `ROD_ACT_ANALOG:
            begin
                ao_wr_out = result_in; // RULE_05
                ao_val_out = scale(value_in, range_in); // RULE_05
            end
            `ROD_ACT_DIGITAL:
            begin
                do_wr_out = 1'b1;
                do_lvl_out = result_in ? dig_level_in : ~dig_level_in; // RULE_06
            end
            `ROD_ACT_COUNTER:
            begin
                if (result_in)
                    cnt_cmd_out = cnt_true_in; // RULE_07
                else if (cnt_true_in == `ROD_CNT_START)
                    cnt_cmd_out = `ROD_CNT_STOP; // RULE_08
                else if (cnt_true_in == `ROD_CNT_STOP)
                    cnt_cmd_out = `ROD_CNT_START; // RULE_08
                else
                    cnt_cmd_out = `ROD_CNT_NOP; // RULE_08
            end
            default:
            begin
                // None and the pulse, timer, flag, message and icount types produce no action here
                ao_wr_out = 1'b0; // RULE_03
            end
        endcase
    end

endmodule // rod_slot
`default_nettype wire

/* rod_dispatch.v */
// Purpose: Rule output stage fanning one result to three action slots
// Assumes: RESULT_VALID_IN is a one-cycle pulse from the execution stage
// Notes: Remote commands queue one per cycle, slot 0 first; no buffering
`timescale 1ns/10ps
`default_nettype none
`include "rod_defs.vh"
module rod_dispatch #(
    parameter VAL_W = 12,
    parameter CH_W = 4,
    parameter IP_ENTRIES = 8
)
(
    // Clock and reset
    input wire CORE_CLK_IN,
    input wire RESET_IN,
    // Result from execution stage
    input wire RESULT_VALID_IN,
    input wire RESULT_IN,
    // Slot configuration, three slots packed, slot 0 in low bits
    input wire [3*3-1:0] DEST_SEL_IN,
    input wire [3*4-1:0] ACT_TYPE_IN,
    input wire [3*2-1:0] RANGE_SEL_IN,
    input wire [3*CH_W-1:0] CHANNEL_IN,
    input wire [3*VAL_W-1:0] VALUE_IN,
    input wire [2:0] DIG_LEVEL_IN,
    input wire [3*2-1:0] CNT_TRUE_IN,
    input wire CFG_WR_IN,
    // IP address table
    input wire [IP_ENTRIES*32-1:0] IP_TABLE_IN,
    // Local analog output
    output reg LOC_AO_WR_OUT,
    output reg [CH_W-1:0] LOC_AO_CH_OUT,
    output reg [VAL_W-1:0] LOC_AO_VAL_OUT,
    // Local digital output
    output reg LOC_DO_WR_OUT,
    output reg [CH_W-1:0] LOC_DO_CH_OUT,
    output reg LOC_DO_LVL_OUT,
    // Local counter channel
    output reg LOC_CNT_WR_OUT,
    output reg [CH_W-1:0] LOC_CNT_CH_OUT,
    output reg [1:0] LOC_CNT_CMD_OUT,
    // Remote command port
    output wire NET_VALID_OUT,
    input wire NET_READY_IN,
    output reg [31:0] NET_IP_OUT,
    output reg [3:0] NET_ACT_OUT,
    output reg [CH_W-1:0] NET_CH_OUT,
    output reg [VAL_W-1:0] NET_DATA_OUT,
    output wire BUSY_OUT
);

    localparam ST_IDLE = 2'b01;
    localparam ST_SEND = 2'b10;

    reg [3*4-1:0] act_type_r;
    reg [1:0] state_r;
    reg [2:0] pend_r;
    reg [1:0] idx_r;
    reg [3*4-1:0] q_act_r;
    reg [3*CH_W-1:0] q_ch_r;
    reg [3*VAL_W-1:0] q_data_r;
    reg [3*3-1:0] q_dest_r;

    wire [2:0] ao_wr;
    wire [3*VAL_W-1:0] ao_val;
    wire [2:0] do_wr;
    wire [2:0] do_lvl;
    wire [3*2-1:0] cnt_cmd;

    // Configured action types; reset to none
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
            act_type_r <= {3{`ROD_ACT_NONE}}; // RULE_03
        else if (CFG_WR_IN)
            act_type_r <= ACT_TYPE_IN; // RULE_04
    end

    genvar g;
    generate
        for (g = 0; g < `ROD_NUM_SLOTS; g = g + 1)
        begin : slot
            rod_slot #(.VAL_W(VAL_W)) u_slot (
                .result_in(RESULT_IN), // RULE_01
                .act_type_in(act_type_r[g*4 +: 4]),
                .range_in(RANGE_SEL_IN[g*2 +: 2]),
                .value_in(VALUE_IN[g*VAL_W +: VAL_W]),
                .dig_level_in(DIG_LEVEL_IN[g]),
                .cnt_true_in(CNT_TRUE_IN[g*2 +: 2]),
                .ao_wr_out(ao_wr[g]),
                .ao_val_out(ao_val[g*VAL_W +: VAL_W]),
                .do_wr_out(do_wr[g]),
                .do_lvl_out(do_lvl[g]),
                .cnt_cmd_out(cnt_cmd[g*2 +: 2])
            );
        end
    endgenerate

    function is_local;
        input [2:0] d;
        begin
            is_local = (d == `ROD_DEST_LOCAL); // RULE_02
        end
    endfunction

    // Local actions; later slots win on a shared port in the same cycle
    integer i;
    integer j;
    integer k;
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            LOC_AO_WR_OUT <= 1'b0;
            LOC_AO_CH_OUT <= {CH_W{1'b0}};
            LOC_AO_VAL_OUT <= {VAL_W{1'b0}};
            LOC_DO_WR_OUT <= 1'b0;
            LOC_DO_CH_OUT <= {CH_W{1'b0}};
            LOC_DO_LVL_OUT <= 1'b0;
            LOC_CNT_WR_OUT <= 1'b0;
            LOC_CNT_CH_OUT <= {CH_W{1'b0}};
            LOC_CNT_CMD_OUT <= `ROD_CNT_NOP;
        end
        else
        begin
            LOC_AO_WR_OUT <= 1'b0;
            LOC_DO_WR_OUT <= 1'b0;
            LOC_CNT_WR_OUT <= 1'b0;
            for (i = 0; i < 3; i = i + 1)
            begin
                if (RESULT_VALID_IN && is_local(DEST_SEL_IN[i*3 +: 3])) // RULE_09
                begin
                    if (ao_wr[i])
                    begin
                        LOC_AO_WR_OUT <= 1'b1; // RULE_10
                        LOC_AO_CH_OUT <= CHANNEL_IN[i*CH_W +: CH_W];
                        LOC_AO_VAL_OUT <= ao_val[i*VAL_W +: VAL_W];
                    end
                    if (do_wr[i])
                    begin
                        LOC_DO_WR_OUT <= 1'b1; // RULE_10
                        LOC_DO_CH_OUT <= CHANNEL_IN[i*CH_W +: CH_W];
                        LOC_DO_LVL_OUT <= do_lvl[i];
                    end
                    if (act_type_r[i*4 +: 4] == `ROD_ACT_COUNTER && cnt_cmd[i*2 +: 2] != `ROD_CNT_NOP)
                    begin
                        LOC_CNT_WR_OUT <= 1'b1; // RULE_10
                        LOC_CNT_CH_OUT <= CHANNEL_IN[i*CH_W +: CH_W];
                        LOC_CNT_CMD_OUT <= cnt_cmd[i*2 +: 2];
                    end
                end
            end
        end
    end

    // Lowest pending slot goes first so remote commands keep slot order
    function [1:0] first_slot;
        input [2:0] p;
        begin
            if (p[0])
                first_slot = 2'h0;
            else if (p[1])
                first_slot = 2'h1;
            else
                first_slot = 2'h2;
        end
    endfunction

    // Remote sequencer; results arriving while busy are dropped
    // Next index comes from what is left once the current slot is done, so a gap is skipped
    wire [2:0] pend_left = pend_r & ~(3'b001 << idx_r);
    wire [1:0] idx_nxt = first_slot(pend_left);
    // Table entry n-1 for selector n; held in three bits so it never leaves the table
    wire [2:0] ip_sel = q_dest_r[idx_r*3 +: 3] - 3'h1;
    assign NET_VALID_OUT = (state_r == ST_SEND);
    assign BUSY_OUT = (state_r == ST_SEND);

    always @*
    begin
        NET_IP_OUT = IP_TABLE_IN[ip_sel*32 +: 32]; // RULE_02
        NET_ACT_OUT = q_act_r[idx_r*4 +: 4];
        NET_CH_OUT = q_ch_r[idx_r*CH_W +: CH_W];
        NET_DATA_OUT = q_data_r[idx_r*VAL_W +: VAL_W];
    end

    reg [2:0] want;
    always @*
    begin
        for (j = 0; j < 3; j = j + 1)
            want[j] = !is_local(DEST_SEL_IN[j*3 +: 3]) && (ao_wr[j] || do_wr[j] ||
                (act_type_r[j*4 +: 4] == `ROD_ACT_COUNTER && cnt_cmd[j*2 +: 2] != `ROD_CNT_NOP));
    end

    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_r <= ST_IDLE;
            pend_r <= 3'b000;
            idx_r <= 2'd0;
            q_act_r <= {12{1'b0}};
            q_ch_r <= {3*CH_W{1'b0}};
            q_data_r <= {3*VAL_W{1'b0}};
            q_dest_r <= {9{1'b0}};
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (RESULT_VALID_IN && want != 3'b000)
                    begin
                        pend_r <= want; // RULE_10
                        idx_r <= first_slot(want);
                        q_dest_r <= DEST_SEL_IN;
                        q_ch_r <= CHANNEL_IN;
                        for (k = 0; k < 3; k = k + 1)
                        begin
                            q_act_r[k*4 +: 4] <= act_type_r[k*4 +: 4];
                            if (do_wr[k])
                                q_data_r[k*VAL_W +: VAL_W] <= {{(VAL_W-1){1'b0}}, do_lvl[k]};
                            else if (ao_wr[k])
                                q_data_r[k*VAL_W +: VAL_W] <= ao_val[k*VAL_W +: VAL_W];
                            else
                                q_data_r[k*VAL_W +: VAL_W] <= {{(VAL_W-2){1'b0}}, cnt_cmd[k*2 +: 2]};
                        end
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (NET_READY_IN)
                    begin
                        pend_r[idx_r] <= 1'b0;
                        if (pend_left == 3'b000)
                            state_r <= ST_IDLE;
                        else
                            idx_r <= idx_nxt; // RULE_10
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // rod_dispatch
`default_nettype wire

/* rod_dispatch_props.sv */
// Purpose: Port-level checks for rod_dispatch
// Assumes: Single clock, synchronous active-high reset
// Notes: Sees only top-level ports
`timescale 1ns/10ps
`default_nettype none
module rod_dispatch_props #(
    parameter VAL_W = 12
)
(
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic RESULT_VALID_IN,
    input wire logic RESULT_IN,
    input wire logic NET_READY_IN,
    input wire logic LOC_AO_WR_OUT,
    input wire logic LOC_DO_WR_OUT,
    input wire logic LOC_CNT_WR_OUT,
    input wire logic [1:0] LOC_CNT_CMD_OUT,
    input wire logic NET_VALID_OUT,
    input wire logic BUSY_OUT,
    input wire logic [31:0] NET_IP_OUT,
    input wire logic [3:0] NET_ACT_OUT,
    input wire logic [VAL_W-1:0] NET_DATA_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    reset_quiet_a: assert property (disable iff (1'b0) RESET_IN |=> !LOC_AO_WR_OUT && !LOC_DO_WR_OUT && !NET_VALID_OUT)
        else $error("outputs active after reset");
    valid_busy_a: assert property (NET_VALID_OUT == BUSY_OUT)
        else $error("net valid and busy differ");
    net_hold_a: assert property (NET_VALID_OUT && !NET_READY_IN |=>
        NET_VALID_OUT && $stable({NET_IP_OUT, NET_ACT_OUT, NET_DATA_OUT}))
        else $error("net command changed while stalled");
    ao_true_a: assert property (LOC_AO_WR_OUT |-> $past(RESULT_VALID_IN && RESULT_IN))
        else $error("analog write without true result");
    ao_false_a: assert property (RESULT_VALID_IN && !RESULT_IN |=> !LOC_AO_WR_OUT)
        else $error("analog write on false result");
    do_cause_a: assert property (LOC_DO_WR_OUT |-> $past(RESULT_VALID_IN))
        else $error("digital write without result");
    cnt_false_a: assert property (LOC_CNT_WR_OUT |->
        $past(RESULT_VALID_IN) && LOC_CNT_CMD_OUT != 2'h0 && (LOC_CNT_CMD_OUT != 2'h3 || $past(RESULT_IN)))
        else $error("bad counter command");
    net_start_a: assert property ($rose(NET_VALID_OUT) |-> $past(RESULT_VALID_IN))
        else $error("net command without result");
    net_kind_a: assert property (NET_VALID_OUT |-> NET_ACT_OUT inside {4'h1, 4'h2, 4'h3})
        else $error("net command of unhandled kind");
endmodule // rod_dispatch_props
bind rod_dispatch rod_dispatch_props #(.VAL_W(VAL_W)) i_props (.CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN),
    .RESULT_VALID_IN(RESULT_VALID_IN), .RESULT_IN(RESULT_IN), .NET_READY_IN(NET_READY_IN),
    .LOC_AO_WR_OUT(LOC_AO_WR_OUT), .LOC_DO_WR_OUT(LOC_DO_WR_OUT), .LOC_CNT_WR_OUT(LOC_CNT_WR_OUT),
    .LOC_CNT_CMD_OUT(LOC_CNT_CMD_OUT), .NET_VALID_OUT(NET_VALID_OUT), .BUSY_OUT(BUSY_OUT),
    .NET_IP_OUT(NET_IP_OUT), .NET_ACT_OUT(NET_ACT_OUT), .NET_DATA_OUT(NET_DATA_OUT));
`default_nettype wire

/* rod_net_peer.sv */
// Purpose: Remote module taking network commands
// Assumes: Ready may stall at any time
// Notes: Accepted commands are logged for the bench
`timescale 1ns/10ps
`default_nettype none
module rod_net_peer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [51:0] cmd_in,
    output logic ready_out
);
    logic [51:0] got [$];
    logic [15:0] lfsr_r;
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            lfsr_r <= 16'hACE1;
            ready_out <= 1'b0;
        end
        else
        begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            // Stalls about one cycle in four
            ready_out <= lfsr_r[0] | lfsr_r[1];
            if (valid_in && ready_out)
                got.push_back(cmd_in);
        end
    end
endmodule // rod_net_peer
`default_nettype wire

/* rod_dispatch_tb_top.sv */
// Purpose: Random self-checking bench for rod_dispatch
// Assumes: Remote slots are checked against the peer log
// Notes: Next new result waits until busy drops; repeats on every fourth pass arrive while busy and remotes drop them
`timescale 1ns/10ps
`default_nettype none
`include "rod_defs.vh"
module rod_dispatch_tb_top;
    logic clk = 1'b0, rst = 1'b1, rv = 1'b0, res = 1'b0, cfg = 1'b0, nr, nv, busy;
    logic [8:0] dst = 9'h0;
    logic [11:0] act = 12'h0, ch = 12'h0, aval, ndat;
    logic [5:0] rng = 6'h0, cnt = 6'h0;
    logic [35:0] val = 36'h0;
    logic [2:0] lvl = 3'h0;
    logic [255:0] ipt = {8{32'h0A000001}} + 256'h70000000600000005000000040000000300000002000000010000000;
    logic aw, dw, cw, dlvl;
    logic [3:0] ach, dch, cch, nact, nch;
    logic [1:0] ccmd;
    logic [31:0] nip, s = 32'd23009;
    logic [51:0] eq [$];
    int n_mismatch = 0, n_tests = 0;
    rod_dispatch i_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .RESULT_VALID_IN(rv), .RESULT_IN(res),
        .DEST_SEL_IN(dst), .ACT_TYPE_IN(act), .RANGE_SEL_IN(rng), .CHANNEL_IN(ch), .VALUE_IN(val),
        .DIG_LEVEL_IN(lvl), .CNT_TRUE_IN(cnt), .CFG_WR_IN(cfg), .IP_TABLE_IN(ipt), .LOC_AO_WR_OUT(aw),
        .LOC_AO_CH_OUT(ach), .LOC_AO_VAL_OUT(aval), .LOC_DO_WR_OUT(dw), .LOC_DO_CH_OUT(dch),
        .LOC_DO_LVL_OUT(dlvl), .LOC_CNT_WR_OUT(cw), .LOC_CNT_CH_OUT(cch), .LOC_CNT_CMD_OUT(ccmd),
        .NET_VALID_OUT(nv), .NET_READY_IN(nr), .NET_IP_OUT(nip), .NET_ACT_OUT(nact), .NET_CH_OUT(nch),
        .NET_DATA_OUT(ndat), .BUSY_OUT(busy));
    rod_net_peer i_peer (.clk_in(clk), .rst_in(rst), .valid_in(nv), .cmd_in({nip, nact, nch, ndat}),
        .ready_out(nr));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function automatic logic [11:0] scl(input logic [11:0] v, input logic [1:0] r);
        return (r == `ROD_RANGE_0_5V) ? v >> 1 : (r == `ROD_RANGE_4_20MA) ? v - (v >> 2) + 12'h3FF : v;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        logic [17:0] ea, ed, ec;
        logic [11:0] dat;
        logic [3:0] a;
        logic [2:0] d;
        logic hit;
        int t;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        act = 12'h321;
        // No configuration strobe yet: every slot stays idle
        repeat (4)
        begin
            rv = 1'b1;
            res = ~res;
            @(negedge clk);
            chk({aw, dw, cw, nv}, 4'h0);
        end
        rv = 1'b0;
        for (int i = 0; i < 300; i++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                dst[3*k+:3] = (xs() % 3 == 0) ? 3'(1 + xs() % 7) : `ROD_DEST_LOCAL;
                act[4*k+:4] = (i < 9) ? 4'(i) : 4'(xs() % 9);
                cnt[2*k+:2] = 2'(1 + xs() % 3);
            end
            {rng, ch, val, lvl} = {xs(), xs()};
            cfg = 1'b1;
            @(negedge clk);
            cfg = 1'b0;
            rv = 1'b1;
            res = xs();
            {ea, ed, ec} = '0;
            for (int k = 0; k < 3; k++)
            begin
                a = act[4*k+:4];
                d = dst[3*k+:3];
                dat = 12'h0;
                hit = 1'b0;
                // An analog value of zero is still a write, so the action is flagged apart from its data
                if (a == `ROD_ACT_ANALOG && res)
                begin
                    hit = 1'b1;
                    dat = scl(val[12*k+:12], rng[2*k+:2]);
                end
                if (a == `ROD_ACT_DIGITAL)
                begin
                    hit = 1'b1;
                    dat = {11'h0, lvl[k] ^ ~res};
                end
                if (a == `ROD_ACT_COUNTER)
                begin
                    dat = res ? cnt[2*k+:2] : (cnt[2*k+:2] == 2'h3) ? 2'h0 : 2'h3 - cnt[2*k+:2];
                    hit = (dat != 12'h0);
                end
                if (hit && d != `ROD_DEST_LOCAL)
                    eq.push_back({ipt[32*(d-1)+:32], a, ch[4*k+:4], dat});
                else if (hit)
                    case (a)
                        `ROD_ACT_ANALOG: ea = {2'h1, ch[4*k+:4], dat};
                        `ROD_ACT_DIGITAL: ed = {2'h1, ch[4*k+:4], dat};
                        default: ec = {2'h1, ch[4*k+:4], dat};
                    endcase
            end
            @(negedge clk);
            // Every fourth pass repeats the result while remote commands drain: locals apply, remotes drop
            rv = (i % 4 == 3) && (busy === 1'b1);
            chk({aw, dw, cw}, {ea[16], ed[16], ec[16]});
            if (ea[16])
                chk({ach, aval}, ea[15:0]);
            if (ed[16])
                chk({dch, dlvl}, {ed[15:12], ed[0]});
            if (ec[16])
                chk({cch, ccmd}, {ec[15:12], ec[1:0]});
            if (rv)
            begin
                @(negedge clk);
                rv = 1'b0;
                chk({aw, dw, cw}, {ea[16], ed[16], ec[16]});
            end
            for (t = 0; t < 200 && busy !== 1'b0; t++)
                @(negedge clk);
            if (t == 200)
            begin
                n_mismatch++;
                tally_and_finish();
            end
            chk(i_peer.got.size(), eq.size());
            foreach (eq[j])
                chk(i_peer.got[j], eq[j]);
            eq.delete();
            i_peer.got.delete();
        end
        tally_and_finish();
    end
endmodule // rod_dispatch_tb_top
`default_nettype wire
